/* dv/pin_function_and_mode_latch_bench.sv */
// self-checking bench for the pin function and mode latch
`timescale 1ns/10ps
module pin_function_and_mode_latch_bench;
	logic clk = 1'b0, reset_n = 1'b0, stop_mode = 1'b0, debug_pin_in = 1'b1;
	logic clock_monitor_fail = 1'b0, watchdog_timer_fail = 1'b0;
	logic run_enable, reset_pin_in, reset_pin_out, reset_pin_oe;
	logic debug_pin_pullup, tag_high_input, osc_type_select;
	logic [2:0] mcu_mode;
	logic [7:0] port_a_in = 8'h00, port_b_in = 8'h00, gpio_a_out = 8'h00;
	logic [7:0] gpio_a_oe = 8'h00, gpio_b_out = 8'h00, gpio_b_oe = 8'h00;
	logic [15:0] ext_addr_data = 16'h0000, ext_data_in;
	logic ext_drive_data = 1'b0, cpu_bus_idle = 1'b0, third_timer_sel = 1'b0;
	logic [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe;
	logic [7:0] port_e_in = 8'h00, gpio_e_out = 8'h00, gpio_e_oe = 8'h00;
	logic [1:0] queue_status = 2'h0, port_e_pulldown, s_axi_bresp, s_axi_rresp;
	logic ext_access = 1'b0, ext_slow_access = 1'b0;
	logic ext_write = 1'b0, ext_low_strobe = 1'b0;
	logic [7:0] port_e_out, port_e_oe, port_e_pullup;
	logic [7:0] port_s_pull_en, port_s_pull_pol;
	logic free_cycle_flag, bus_clock_en, ext_write_allowed, port_u_low_is_timer;
	logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic hold_low = 1'b1;
	logic [5:0] rise_cycles = 6'h04;
	logic [2:0] m;
	logic osc;
	int fail_count = 0, comparisons = 0, seed = 32'hA1D6, n;

	always #2 clk = ~clk;

	pin_function_and_mode_latch i_dut (.*);
	reset_line_model i_line (.clk, .reset_pin_oe, .reset_pin_out, .hold_low,
		.rise_cycles, .reset_pin_in);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("compares %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic bound(input int k);
		if (k >= 400) begin
			fail_count++;
			$display("ERROR %0t: wait timed out", $time);
			test_done;
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] v,
		input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && k < 400);
		bound(k);
		s_axi_bready <= 1'b0;
		check(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic rd(input logic [5:0] a, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && k < 400);
		bound(k);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		check(32'(s_axi_rresp), 32'(er));
	endtask

	task automatic wait_run;
		int k;
		k = 0;
		while (!run_enable && k < 400) begin
			@(posedge clk);
			k++;
		end
		bound(k);
		repeat (2) @(posedge clk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			osc = 1'($random(seed));
			@(posedge clk);
			reset_n <= 1'b0;
			hold_low <= 1'b1;
			debug_pin_in <= m[2];
			port_e_in <= {osc, m[1:0], 5'h00};
			repeat (10) @(posedge clk);
			check(32'(port_e_pulldown), 32'h3);
			reset_n <= 1'b1;
			hold_low <= 1'b0;
			wait_run;
			check(32'(mcu_mode[2]), 32'(m[2]));
			check(32'(mcu_mode[1:0]), 32'(m[1:0]));
			check(32'(osc_type_select), 32'(osc));
			check(32'(port_s_pull_en), 32'hFF);
			if (m != 3'h4) check(32'(port_e_oe[4]), 32'h1);
			if (m == 3'h4) begin
				check(32'(port_e_pullup[4]), 32'h1);
				wr(6'h00, 32'h0, 2'h0);
				@(posedge clk);
				check(32'(port_e_pullup[4]), 32'h0);
			end
			rd(6'h0C, 2'h0);
			check(32'(d[3:0]), 32'({osc, m}));
			rd(6'h08, 2'h0);
			check(32'({d[3:2], d[0]}), 32'({2'h3, m[0]}));
			rd(6'h04, 2'h0);
			if (m == 3'h2) check(32'(d[3:2]), 32'h3);
			if (m == 3'h2 || m == 3'h4)
				check(32'(ext_write_allowed), 32'(m == 3'h2));
			wr(6'h0C, 32'h0, 2'h2);
			rd(6'h3C, 2'h2);
			wr(6'h04, 32'h80, 2'h0);
			cpu_bus_idle <= 1'b1;
			repeat (4) @(posedge clk);
			check(32'(free_cycle_flag), 32'(m[0]));
			cpu_bus_idle <= 1'b0;
		end
		for (int j = 0; j < 2; j++) begin
			@(posedge clk);
			clock_monitor_fail <= (j == 0);
			watchdog_timer_fail <= (j == 1);
			rise_cycles <= 6'h1E;
			@(posedge clk);
			clock_monitor_fail <= 1'b0;
			watchdog_timer_fail <= 1'b0;
			repeat (4) @(posedge clk);
			check(32'(reset_pin_oe), 32'h1);
			wait_run;
			check(32'(mcu_mode), 32'h7);
		end
		repeat (300) begin
			@(posedge clk);
			{gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe} <= 32'($random(seed));
			{port_a_in, port_b_in, port_e_in, gpio_e_out} <= 32'($random(seed));
			{ext_addr_data, gpio_e_oe} <= 24'($random(seed));
			{ext_drive_data, cpu_bus_idle, queue_status, ext_access} <=
				5'($random(seed));
			{ext_write, ext_low_strobe, third_timer_sel} <= 3'($random(seed));
		end
		@(posedge clk);
		check(32'(port_u_low_is_timer), 32'(third_timer_sel));
		@(posedge clk);
		check(32'(port_e_out[6:5]), 32'(queue_status));
		check(32'({port_a_out, port_b_out}), 32'(ext_addr_data));
		check(32'(ext_data_in), 32'({port_a_in, port_b_in}));
		wr(6'h08, 32'h10, 2'h0);
		debug_pin_in <= 1'b0;
		repeat (6) @(posedge clk);
		check(32'(tag_high_input), 32'h1);
		debug_pin_in <= 1'b1;
		repeat (6) @(posedge clk);
		check(32'(tag_high_input), 32'h0);
		stop_mode <= 1'b1;
		repeat (2) @(posedge clk);
		n = 0;
		repeat (20) begin
			@(posedge clk);
			n += 32'(bus_clock_en);
		end
		check(32'(n), 32'h0);
		stop_mode <= 1'b0;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			n += 32'(bus_clock_en);
		end
		check(32'(n), 32'hA);
		test_done;
	end
endmodule

/* dv/pin_mux_monitor.sv */
// assertion checker for the pin function and mode latch
`timescale 1ns/10ps
module pin_mux_monitor (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// reset and mode
	input wire logic       clock_monitor_fail,
	input wire logic       watchdog_timer_fail,
	input wire logic       stop_mode,
	input wire logic       run_enable,
	input wire logic       reset_pin_out,
	input wire logic       reset_pin_oe,
	input wire logic       debug_pin_in,
	input wire logic       debug_pin_pullup,
	input wire logic [2:0] mcu_mode,
	input wire logic       osc_type_select,
	// ports
	input wire logic [7:0] port_e_in,
	input wire logic [7:0] gpio_a_out,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_e_out,
	input wire logic [1:0] port_e_pulldown,
	input wire logic       free_cycle_flag,
	input wire logic       bus_clock_en,
	// bus handshake
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ****************************************
	// pin, mode and bus handshake checks
	// ****************************************
	AST_RST_OPEN_DRAIN: assert property (reset_pin_out == 1'b0)
		else $error("reset pin driven high");
	AST_FAIL_DRIVES_LOW: assert property ((watchdog_timer_fail ||
		clock_monitor_fail) && run_enable |-> ##[1:4] reset_pin_oe)
		else $error("failure did not pull reset low");
	AST_NO_RUN_IN_DRIVE: assert property (reset_pin_oe |-> !run_enable)
		else $error("running while reset driven");
	AST_DEBUG_PULLUP: assert property (debug_pin_pullup == 1'b1)
		else $error("debug pull-up off");
	AST_STRAP_CAPTURE: assert property ($rose(run_enable) |->
		mcu_mode == {debug_pin_in, port_e_in[6], port_e_in[5]}
		&& osc_type_select == port_e_in[7])
		else $error("straps not captured");
	AST_MODE_HOLD: assert property (run_enable && $past(run_enable) |->
		$stable(mcu_mode) && $stable(osc_type_select))
		else $error("latched mode changed");
	AST_PULLDOWN_OFF: assert property (run_enable |-> port_e_pulldown == 2'h0)
		else $error("pull-downs on while running");
	AST_FREE_CYCLE_EXP: assert property (run_enable && free_cycle_flag |-> mcu_mode[0])
		else $error("free cycle flag outside expanded mode");
	AST_PORT_A_GPIO: assert property (run_enable && !mcu_mode[0] |=>
		port_a_out == $past(gpio_a_out))
		else $error("port A not general I/O");
	AST_STOP_HALT: assert property (stop_mode && $past(stop_mode)
		&& $past(stop_mode, 2) |-> !bus_clock_en && $stable(port_e_out[4]))
		else $error("bus clock in stop mode");
	AST_HALF_RATE: assert property (run_enable && $past(run_enable) && !stop_mode
		&& !$past(stop_mode) |-> bus_clock_en != $past(bus_clock_en))
		else $error("bus clock not half rate");
	AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
endmodule

bind pin_function_and_mode_latch pin_mux_monitor i_mon (.clk, .reset_n,
	.clock_monitor_fail, .watchdog_timer_fail, .stop_mode, .run_enable,
	.reset_pin_out, .reset_pin_oe, .debug_pin_in, .debug_pin_pullup,
	.mcu_mode, .osc_type_select, .port_e_in, .gpio_a_out, .port_a_out,
	.port_e_out,
	.port_e_pulldown, .free_cycle_flag, .bus_clock_en, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rvalid, .s_axi_rready);

/* dv/reset_line_model.sv */
// external reset line: open-drain wire, pull-up and slow rise
`timescale 1ns/10ps
module reset_line_model (
	// clock
	input  wire logic       clk,
	// device side of the pin
	input  wire logic       reset_pin_oe,
	input  wire logic       reset_pin_out,
	// outside reset source and rise time
	input  wire logic       hold_low,
	input  wire logic [5:0] rise_cycles,
	output logic            reset_pin_in
);
	logic [5:0] rise_r = 6'h00;
	logic       drive_low;

	assign drive_low = (reset_pin_oe && !reset_pin_out) || hold_low;

	always_ff @(posedge clk) begin
		if (drive_low)
			rise_r <= rise_cycles;
		else if (rise_r != 6'h00)
			rise_r <= rise_r - 6'h01;
	end

	assign reset_pin_in = !drive_low && (rise_r == 6'h00);
endmodule

/* inc/pin_mux_pkg.sv */
// types for the pin function and mode latch
package pin_mux_pkg;
	typedef enum logic [2:0] {
		RST_IDLE  = 3'h0,
		RST_DRIVE = 3'h1,
		RST_RISE  = 3'h3,
		RST_RUN   = 3'h2
	} rst_state_t;
	typedef enum logic [2:0] {
		MODE_SPECIAL_SINGLE  = 3'h0,
		MODE_EMUL_NARROW     = 3'h1,
		MODE_SPECIAL_TEST    = 3'h2,
		MODE_EMUL_WIDE       = 3'h3,
		MODE_NORMAL_SINGLE   = 3'h4,
		MODE_NORMAL_NARROW   = 3'h5,
		MODE_PERIPHERAL      = 3'h6,
		MODE_NORMAL_WIDE     = 3'h7
	} mcu_mode_t;
endpackage

/* inc/pin_mux_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH
`define OFS_PULL_UP_CTRL   6'h00
`define OFS_PORT_E_ASSIGN  6'h04
`define OFS_EXT_BUS_CTRL   6'h08
`define OFS_MODE_STATUS    6'h0C
`define OFS_PORT_S_PULL    6'h10
`define OFS_RESET_CTRL     6'h14
// pull-up control fields
`define PUC_PORT_E_PUE     4
// port E assign fields
`define PEA_FREE_CYC_EN    7
`define PEA_CLK_OUT_DIS    4
`define PEA_LSTROBE_EN     3
`define PEA_RW_EN          2
// external bus control fields
`define EBC_STRETCH_EN     0
`define EBC_INTERNAL_VISIBILITY           1
`define EBC_STR_CNT_LO     2
`define EBC_TAG_EN         4
// reset control fields
`define RC_SOFT_RESET      0
// reset values
`define PUC_RESET          8'h10
`define PORT_S_PULL_RESET  8'hFF
`define STR_CNT_RESET      2'h3
// timing counts: reset low time in clock cycles, rise time in bus-clock cycles
`define RESET_LOW_CYCLES   16
`define RESET_RISE_CYCLES  32
`endif

/* verilog/pin_function_and_mode_latch.sv */
// pin function mux, mode strap latch and reset line control
//
// Operation
// - any reset source pulls reset line low, sequence gates normal run
// - clock monitor or watchdog failure drives reset line open-drain
// - debug pin level latched as mode bit C at reset release
// - expanded tagging: low debug pin at falling bus clock tags high half
// - debug pin pseudo-open-drain, pull-up always on
// - ports A/B general I/O, expanded modes carry address/data bus
// - expanded, enabled: free-cycle output high when CPU skips bus
// - oscillator pin latched at release; low Pierce, high Colpitts default
// - port E6 into mode bit B, E5 into mode bit A at release
// - port E6/E5 pull-downs active only while reset line low
// - port E6/E5 double as queue status 1 and 0 outputs
// - normal single-chip: E4 pull-up on from reset, software may clear
// - other modes: E4 starts as bus clock output
// - bus clock runs at half crystal rate out of reset
// - bus clock output set by disable, visibility and stretch bits
// - stop mode halts all clocks including bus clock output
// - bus clock stretch for slow memory, enabled in expanded modes
// - normal narrow: bus clock free for external decode or system clock
// - port E buffer enables mode dependent, test mode enables E3/E2
// - port S pull-ups on at reset; M0,P,Q,T,U pulls off
// - port U3..0 third timer or second PWM, port T first/second timers
// - external writes blocked until read/write pin enable set
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "pin_mux_regs.svh"

module pin_function_and_mode_latch (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// reset sources, stop mode and run enable
	input  wire logic        clock_monitor_fail,
	input  wire logic        watchdog_timer_fail,
	input  wire logic        stop_mode,
	output logic             run_enable,
	// reset pin, open drain
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe,
	// debug pin
	input  wire logic        debug_pin_in,
	output logic             debug_pin_pullup,
	output logic             tag_high_input,
	// strap results
	output logic [2:0]       mcu_mode,
	output logic             osc_type_select,
	// port A and B
	input  wire logic [7:0]  port_a_in,
	input  wire logic [7:0]  port_b_in,
	input  wire logic [7:0]  gpio_a_out,
	input  wire logic [7:0]  gpio_a_oe,
	input  wire logic [7:0]  gpio_b_out,
	input  wire logic [7:0]  gpio_b_oe,
	input  wire logic [15:0] ext_addr_data,
	input  wire logic        ext_drive_data,
	output logic [7:0]       port_a_out,
	output logic [7:0]       port_a_oe,
	output logic [7:0]       port_b_out,
	output logic [7:0]       port_b_oe,
	output logic [15:0]      ext_data_in,
	// port E
	input  wire logic [7:0]  port_e_in,
	input  wire logic [7:0]  gpio_e_out,
	input  wire logic [7:0]  gpio_e_oe,
	input  wire logic        cpu_bus_idle,
	input  wire logic [1:0]  queue_status,
	input  wire logic        ext_access,
	input  wire logic        ext_slow_access,
	input  wire logic        ext_write,
	input  wire logic        ext_low_strobe,
	output logic [7:0]       port_e_out,
	output logic [7:0]       port_e_oe,
	output logic [7:0]       port_e_pullup,
	output logic [1:0]       port_e_pulldown,
	output logic             free_cycle_flag,
	output logic             bus_clock_en,
	output logic             ext_write_allowed,
	// other port pulls and function selects
	input  wire logic        third_timer_sel,
	output logic [7:0]       port_s_pull_en,
	output logic [7:0]       port_s_pull_pol,
	output logic             port_u_low_is_timer,
	// AXI4-Lite slave
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] rst_pin_s;
	logic [1:0] dbg_s;
	logic [1:0] pe_s [0:2];
	logic [2:0] strap_live;

	always_ff @(posedge clk) begin
		rst_pin_s <= {rst_pin_s[0], reset_pin_in};
		dbg_s     <= {dbg_s[0], debug_pin_in};
		pe_s[0]   <= {pe_s[0][0], port_e_in[5]};
		pe_s[1]   <= {pe_s[1][0], port_e_in[6]};
		pe_s[2]   <= {pe_s[2][0], port_e_in[7]};
	end
	assign strap_live = {pe_s[2][1], pe_s[1][1], pe_s[0][1]};

	// ****************************************
	// reset sequence
	// ****************************************
	pin_mux_pkg::rst_state_t st_r;
	logic [5:0]              cnt_r;
	logic                    soft_rst_r;
	logic                    fail_src;
	logic                    line_low;

	assign fail_src = clock_monitor_fail | watchdog_timer_fail | soft_rst_r;
	assign line_low = ~rst_pin_s[1];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r  <= pin_mux_pkg::RST_DRIVE;
			cnt_r <= 6'h00;
		end else begin
			case (st_r)
			pin_mux_pkg::RST_DRIVE: begin
				if (cnt_r == 6'(`RESET_LOW_CYCLES - 1)) begin
					st_r  <= pin_mux_pkg::RST_RISE;
					cnt_r <= 6'h00;
				end else begin
					cnt_r <= cnt_r + 6'h01;
				end
			end
			pin_mux_pkg::RST_RISE: begin
				if (!line_low) begin
					st_r <= pin_mux_pkg::RST_RUN;
				end else if (cnt_r == 6'(2 * `RESET_RISE_CYCLES - 1)) begin
					st_r  <= pin_mux_pkg::RST_DRIVE;
					cnt_r <= 6'h00;
				end else begin
					cnt_r <= cnt_r + 6'h01;
				end
			end
			pin_mux_pkg::RST_RUN: begin
				if (fail_src) begin
					st_r  <= pin_mux_pkg::RST_DRIVE;
					cnt_r <= 6'h00;
				end else if (line_low) begin
					st_r <= pin_mux_pkg::RST_IDLE;
				end
			end
			pin_mux_pkg::RST_IDLE: begin
				// external reset held low
				if (!line_low) begin
					st_r <= pin_mux_pkg::RST_RUN;
				end
			end
			default: st_r <= pin_mux_pkg::RST_DRIVE;
			endcase
		end
	end

	logic in_reset;
	assign in_reset      = (st_r != pin_mux_pkg::RST_RUN);
	assign run_enable    = ~in_reset;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe  = (st_r == pin_mux_pkg::RST_DRIVE);

	// ****************************************
	// strap latch
	// ****************************************
	logic [2:0] mode_r;
	logic       osc_r;
	logic       in_reset_d;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			in_reset_d <= 1'b1;
		end else begin
			in_reset_d <= in_reset;
		end
	end

	always_ff @(posedge clk) begin
		if (in_reset) begin
			mode_r <= {dbg_s[1], strap_live[1], strap_live[0]};
			osc_r  <= strap_live[2];
		end
	end
	assign mcu_mode        = mode_r;
	assign osc_type_select = osc_r;

	logic expanded;
	logic single_norm;
	logic test_mode;
	assign expanded    = mode_r[0];
	assign single_norm = (mode_r == 3'(pin_mux_pkg::MODE_NORMAL_SINGLE));
	assign test_mode   = (mode_r == 3'(pin_mux_pkg::MODE_SPECIAL_TEST));

	// ****************************************
	// control registers
	// ****************************************
	logic [7:0] puc_r;
	logic [7:0] pea_r;
	logic [4:0] ebc_r;
	logic [7:0] pse_r;
	logic [7:0] pss_r;
	logic       wr_fire;
	logic [5:0] wr_addr;
	logic [31:0] wr_data;

	always_ff @(posedge clk) begin
		if (in_reset_d) begin
			puc_r <= `PUC_RESET;
			pea_r <= 8'h00;
			pea_r[`PEA_CLK_OUT_DIS] <= single_norm;
			pea_r[`PEA_RW_EN]       <= test_mode;
			pea_r[`PEA_LSTROBE_EN]  <= test_mode;
			ebc_r <= 5'h00;
			ebc_r[`EBC_STRETCH_EN]  <= expanded;
			ebc_r[`EBC_STR_CNT_LO +: 2] <= `STR_CNT_RESET;
			pse_r <= `PORT_S_PULL_RESET;
			pss_r <= 8'h00;
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= 1'b0;
			if (wr_fire) begin
				case (wr_addr)
				`OFS_PULL_UP_CTRL:  puc_r <= wr_data[7:0];
				`OFS_PORT_E_ASSIGN: pea_r <= wr_data[7:0];
				`OFS_EXT_BUS_CTRL:  ebc_r <= wr_data[4:0];
				`OFS_PORT_S_PULL:   begin
					pse_r <= wr_data[7:0];
					pss_r <= wr_data[15:8];
				end
				`OFS_RESET_CTRL:    soft_rst_r <= wr_data[`RC_SOFT_RESET];
				default: ;
				endcase
			end
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [5:0]  aw_r;
	logic [31:0] w_r;
	logic        aw_ok;

	assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
	assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
	assign wr_addr = aw_r;
	assign wr_data = w_r;
	assign aw_ok   = (aw_r <= `OFS_RESET_CTRL) && (aw_r[1:0] == 2'h0);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			aw_r         <= 6'h00;
			w_r          <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_r      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_r      <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
			end
			if (wr_fire) begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_ok && aw_r != `OFS_MODE_STATUS)
					? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
		`OFS_PULL_UP_CTRL:  rd_mux[7:0]  = puc_r;
		`OFS_PORT_E_ASSIGN: rd_mux[7:0]  = pea_r;
		`OFS_EXT_BUS_CTRL:  rd_mux[4:0]  = ebc_r;
		`OFS_MODE_STATUS:   rd_mux[3:0]  = {osc_r, mode_r};
		`OFS_PORT_S_PULL:   rd_mux[15:0] = {pss_r, pse_r};
		`OFS_RESET_CTRL:    rd_mux       = 32'h0000_0000;
		default:            rd_mux       = 32'h0000_0000;
		endcase
	end

	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= (s_axi_araddr <= `OFS_RESET_CTRL
				&& s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// bus clock divider and stretch
	// ****************************************
	logic       bus_clock_out_r;
	logic [1:0] str_r;
	logic       stretching;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bus_clock_out_r <= 1'b0;
			str_r  <= 2'h0;
		end else if (!stop_mode) begin
			if (bus_clock_out_r && str_r != 2'h0) begin
				str_r <= str_r - 2'h1;
			end else begin
				if (!bus_clock_out_r && ext_slow_access && ebc_r[`EBC_STRETCH_EN]) begin
					str_r <= ebc_r[`EBC_STR_CNT_LO +: 2];
				end
				bus_clock_out_r <= ~bus_clock_out_r;
			end
		end
	end
	assign stretching   = bus_clock_out_r && str_r != 2'h0;
	assign bus_clock_en = bus_clock_out_r & ~stretching & ~stop_mode;

	// ****************************************
	// pin function mux
	// ****************************************
	logic bus_clock_out_pin_on;
	logic tag_en;
	// disable, visibility, ext_access; free clock outside normal single-chip
	assign bus_clock_out_pin_on = ~pea_r[`PEA_CLK_OUT_DIS] &
		(~ext_access | ebc_r[`EBC_INTERNAL_VISIBILITY] | ~single_norm);
	assign tag_en = expanded & ebc_r[`EBC_TAG_EN];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tag_high_input <= 1'b0;
		end else if (bus_clock_out_r && !stretching) begin
			tag_high_input <= tag_en & ~dbg_s[1];
		end
	end
	assign debug_pin_pullup = 1'b1;

	always_ff @(posedge clk) begin
		if (expanded && !in_reset) begin
			port_a_out <= ext_addr_data[15:8];
			port_b_out <= ext_addr_data[7:0];
			port_a_oe  <= {8{ext_drive_data}};
			port_b_oe  <= {8{ext_drive_data}};
		end else begin
			port_a_out <= gpio_a_out;
			port_b_out <= gpio_b_out;
			port_a_oe  <= in_reset ? 8'h00 : gpio_a_oe;
			port_b_oe  <= in_reset ? 8'h00 : gpio_b_oe;
		end
		ext_data_in <= {port_a_in, port_b_in};
	end

	logic [7:0] e_fn;
	logic [7:0] e_sel;
	always_comb begin
		e_fn  = gpio_e_out;
		e_sel = 8'h00;
		e_fn[7]  = cpu_bus_idle;
		e_sel[7] = expanded & pea_r[`PEA_FREE_CYC_EN];
		e_fn[6:5]  = queue_status;
		e_sel[6:5] = {2{expanded}};
		e_fn[4]  = bus_clock_out_r;
		e_sel[4] = bus_clock_out_pin_on;
		e_fn[3]  = ext_low_strobe;
		e_sel[3] = pea_r[`PEA_LSTROBE_EN];
		e_fn[2]  = ~(ext_write & pea_r[`PEA_RW_EN]);
		e_sel[2] = pea_r[`PEA_RW_EN];
	end
	assign ext_write_allowed = pea_r[`PEA_RW_EN];

	always_ff @(posedge clk) begin
		if (in_reset) begin
			port_e_out <= 8'h00;
			port_e_oe  <= 8'h00;
		end else begin
			port_e_out <= e_fn;
			port_e_oe  <= (e_sel | gpio_e_oe) & 8'hFC;
		end
		free_cycle_flag <= ~in_reset & e_sel[7] & cpu_bus_idle;
	end

	// strap pull-downs while reset low; pull-ups
	assign port_e_pulldown = {2{in_reset}};
	assign port_e_pullup   = (puc_r[`PUC_PORT_E_PUE] ? 8'h9F : 8'h00)
		& ~port_e_oe & {8{~in_reset}} | 8'h80 & {8{in_reset}};
	assign port_s_pull_en  = pse_r;
	assign port_s_pull_pol = pss_r;
	assign port_u_low_is_timer = third_timer_sel;

endmodule
